// ===== rtl/mar_pkg.sv
package mar_pkg;

  // ----------------------------------------------------------------
  // datapath geometry
  // ----------------------------------------------------------------
  localparam int DIG_W = 16;
  localparam int MEM_AW = 6;
  localparam int MSIZE_W = 6;
  localparam int SEL_W = 2;
  localparam int SUB_AW = 4;
  localparam int DIG_LG = 4;
  localparam int CNT_W = 12;
  localparam int ENTRY_W = 12;
  localparam int MSEL_W = 2;

  // two montgomery reductions: 2 * 16 bit steps per digit, shift by 5
  localparam int MULT_BIT_SHIFT = 5;
  localparam logic [MEM_AW-1:0] ADDR_LAST = 6'h3F;
  localparam logic [SUB_AW-1:0] SUB_BASE = 4'h0;

  // ----------------------------------------------------------------
  // routine entry addresses
  // ----------------------------------------------------------------
  localparam logic [ENTRY_W-1:0] ENTRY_ADD = 12'h008;
  localparam logic [ENTRY_W-1:0] ENTRY_SUB = 12'h009;
  localparam logic [ENTRY_W-1:0] ENTRY_MULT2 = 12'h00B;
  localparam logic [ENTRY_W-1:0] ENTRY_CLEAR = 12'h00D;

  // ----------------------------------------------------------------
  // host memory select codes
  // ----------------------------------------------------------------
  localparam logic [MSEL_W-1:0] MSEL_A = 2'h0;
  localparam logic [MSEL_W-1:0] MSEL_B = 2'h1;
  localparam logic [MSEL_W-1:0] MSEL_N = 2'h2;
  localparam logic [MSEL_W-1:0] MSEL_T = 2'h3;

  typedef enum {
    ST_IDLE,
    ST_CLEAR,
    ST_ADD,
    ST_SUB,
    ST_SUBFIX,
    ST_MINIT,
    ST_MSTART,
    ST_MPASS,
    ST_MTOP,
    ST_MFINAL,
    ST_COPY
  } mar_state_e;

endpackage : mar_pkg

// ===== rtl/mar_alu_if.sv
`timescale 1ns/10ps
`default_nettype none

interface mar_alu_if;
  logic [mar_pkg::DIG_W-1:0] x;
  logic [mar_pkg::DIG_W-1:0] y;
  logic [mar_pkg::DIG_W-1:0] z;
  logic [mar_pkg::DIG_W-1:0] w;
  logic [1:0] cin;
  logic bin;
  logic [mar_pkg::DIG_W-1:0] sum;
  logic [mar_pkg::DIG_W-1:0] diff;
  logic [1:0] cout;
  logic bout;

  modport core (output x, y, z, w, cin, bin, input sum, diff, cout, bout);
  modport alu (input x, y, z, w, cin, bin, output sum, diff, cout, bout);
endinterface : mar_alu_if

`default_nettype wire

// ===== rtl/mar_digit_alu.sv
`timescale 1ns/10ps
`default_nettype none

// three-input digit adder with 2-bit carry, followed by a borrow subtract
module mar_digit_alu (
  // digit operands and results
  mar_alu_if.alu alu_p
);
  logic [mar_pkg::DIG_W+1:0] total;
  logic [mar_pkg::DIG_W:0] delta;

  always_comb begin
    total = 18'(alu_p.x) + 18'(alu_p.y) + 18'(alu_p.z) + 18'(alu_p.cin);
    delta = {1'b0, total[mar_pkg::DIG_W-1:0]} - {1'b0, alu_p.w} - 17'(alu_p.bin);
    alu_p.sum = total[mar_pkg::DIG_W-1:0];
    alu_p.cout = total[mar_pkg::DIG_W+1:mar_pkg::DIG_W];
    alu_p.diff = delta[mar_pkg::DIG_W-1:0];
    alu_p.bout = delta[mar_pkg::DIG_W];
  end
endmodule : mar_digit_alu

`default_nettype wire

// ===== rtl/mar_routines.sv
`timescale 1ns/10ps
`default_nettype none

module mar_routines (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // routine launch
  input wire logic start,
  input wire logic [mar_pkg::ENTRY_W-1:0] entry_addr,
  input wire logic [mar_pkg::MSIZE_W-1:0] mod_size,
  input wire logic [mar_pkg::SEL_W-1:0] a_sel,
  input wire logic [mar_pkg::SEL_W-1:0] b_sel,
  // operand memory access
  input wire logic mem_wr,
  input wire logic [mar_pkg::MSEL_W-1:0] mem_sel,
  input wire logic [mar_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [mar_pkg::DIG_W-1:0] mem_wdata,
  output logic [mar_pkg::DIG_W-1:0] mem_rdata,
  // status
  output logic busy,
  output logic done
);
  localparam int DW = mar_pkg::DIG_W;
  localparam int AW = mar_pkg::MEM_AW;

  // ----------------------------------------------------------------
  // state and memories
  // ----------------------------------------------------------------
  mar_pkg::mar_state_e state_q, state_d;
  logic [AW-1:0] j_q, j_d;
  logic [mar_pkg::CNT_W-1:0] i_q, i_d;
  logic [1:0] c_q, c_d;
  logic bw_q, bw_d;
  logic ptop_q, ptop_d;
  logic [DW-1:0] prev_q, prev_d;
  logic abit_q, abit_d;
  logic qbit_q, qbit_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic [DW-1:0] rdata_q, rdata_d;

  logic [DW-1:0] mem_a [2**AW];
  logic [DW-1:0] mem_b [2**AW];
  logic [DW-1:0] mem_n [2**AW];
  logic [DW-1:0] mem_t [2**AW];

  logic a_we, b_we, n_we, t_we;
  logic [AW-1:0] a_wa, b_wa, n_wa, t_wa;
  logic [DW-1:0] a_wd, b_wd, n_wd, t_wd;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  logic [AW-1:0] a_idx, b_idx, b_base, bit_dig;
  logic [mar_pkg::CNT_W-1:0] digits, bits_last, half_bits;
  logic last_dig, a_now, q_now;
  logic [1:0] ext;

  assign a_idx = {a_sel, mar_pkg::SUB_BASE} + j_q;
  assign b_idx = {b_sel, mar_pkg::SUB_BASE} + j_q;
  assign b_base = {b_sel, mar_pkg::SUB_BASE};
  assign digits = mar_pkg::CNT_W'(mod_size) + 12'h001;
  assign bits_last = (digits << mar_pkg::MULT_BIT_SHIFT) - 12'h001;
  assign half_bits = digits << mar_pkg::DIG_LG;
  assign last_dig = (j_q == mod_size);
  assign bit_dig = {a_sel, mar_pkg::SUB_BASE} + i_q[mar_pkg::DIG_LG +: AW];
  // multiplier bits of A for the first 16*digits steps, zero for the second reduction
  assign a_now = (i_q < half_bits) ? mem_a[bit_dig][i_q[mar_pkg::DIG_LG-1:0]] : 1'b0;
  assign q_now = mem_t[0][0] ^ (a_now & mem_b[b_base][0]);
  assign ext = c_q + 2'(ptop_q);

  mar_alu_if alu_c ();

  mar_digit_alu u_alu (
    .alu_p(alu_c.alu)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    j_d = j_q;
    i_d = i_q;
    c_d = c_q;
    bw_d = bw_q;
    ptop_d = ptop_q;
    prev_d = prev_q;
    abit_d = abit_q;
    qbit_d = qbit_q;
    done_d = done_q;
    a_we = 1'b0;
    b_we = 1'b0;
    n_we = 1'b0;
    t_we = 1'b0;
    a_wa = mem_addr;
    b_wa = mem_addr;
    n_wa = mem_addr;
    t_wa = mem_addr;
    a_wd = mem_wdata;
    b_wd = mem_wdata;
    n_wd = mem_wdata;
    t_wd = mem_wdata;
    alu_c.x = '0;
    alu_c.y = '0;
    alu_c.z = '0;
    alu_c.w = '0;
    alu_c.cin = c_q;
    alu_c.bin = bw_q;
    case (mem_sel)
      mar_pkg::MSEL_A: rdata_d = mem_a[mem_addr];
      mar_pkg::MSEL_B: rdata_d = mem_b[mem_addr];
      mar_pkg::MSEL_N: rdata_d = mem_n[mem_addr];
      default: rdata_d = mem_t[mem_addr];
    endcase
    case (state_q)
      mar_pkg::ST_IDLE: begin
        if (mem_wr) begin
          a_we = (mem_sel == mar_pkg::MSEL_A);
          b_we = (mem_sel == mar_pkg::MSEL_B);
          n_we = (mem_sel == mar_pkg::MSEL_N);
          t_we = (mem_sel == mar_pkg::MSEL_T);
        end
        j_d = '0;
        c_d = '0;
        bw_d = 1'b0;
        if (start) begin
          done_d = 1'b0;
          case (entry_addr)
            mar_pkg::ENTRY_MULT2: state_d = mar_pkg::ST_MINIT;
            mar_pkg::ENTRY_ADD: state_d = mar_pkg::ST_ADD;
            mar_pkg::ENTRY_SUB: state_d = mar_pkg::ST_SUB;
            mar_pkg::ENTRY_CLEAR: state_d = mar_pkg::ST_CLEAR;
            default: done_d = done_q;
          endcase
        end
      end
      mar_pkg::ST_CLEAR: begin
        // only memories are written here; control state other than j_q, done_q, busy_q and state_q is left alone
        {a_we, b_we, n_we, t_we} = 4'hF;
        {a_wa, b_wa, n_wa, t_wa} = {4{j_q}};
        {a_wd, b_wd, n_wd, t_wd} = '0;
        j_d = j_q + 6'h01;
        if (j_q == mar_pkg::ADDR_LAST) begin
          done_d = 1'b1;
          state_d = mar_pkg::ST_IDLE;
        end
      end
      mar_pkg::ST_ADD: begin
        // sum to scratch, sum minus N to B, choose at the end
        alu_c.x = mem_a[a_idx];
        alu_c.y = mem_b[b_idx];
        alu_c.w = mem_n[j_q];
        t_we = 1'b1;
        t_wa = j_q;
        t_wd = alu_c.sum;
        b_we = 1'b1;
        b_wa = b_idx;
        b_wd = alu_c.diff;
        c_d = alu_c.cout;
        bw_d = alu_c.bout;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          j_d = '0;
          c_d = '0;
          bw_d = 1'b0;
          if (alu_c.cout != 2'h0 || !alu_c.bout) begin
            done_d = 1'b1;
            state_d = mar_pkg::ST_IDLE;
          end else begin
            state_d = mar_pkg::ST_COPY;
          end
        end
      end
      mar_pkg::ST_SUB: begin
        alu_c.x = mem_a[a_idx];
        alu_c.w = mem_b[b_idx];
        b_we = 1'b1;
        b_wa = b_idx;
        b_wd = alu_c.diff;
        bw_d = alu_c.bout;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          j_d = '0;
          c_d = '0;
          bw_d = 1'b0;
          if (alu_c.bout) begin
            state_d = mar_pkg::ST_SUBFIX;
          end else begin
            done_d = 1'b1;
            state_d = mar_pkg::ST_IDLE;
          end
        end
      end
      mar_pkg::ST_SUBFIX: begin
        alu_c.x = mem_b[b_idx];
        alu_c.y = mem_n[j_q];
        b_we = 1'b1;
        b_wa = b_idx;
        b_wd = alu_c.sum;
        c_d = alu_c.cout;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          done_d = 1'b1;
          state_d = mar_pkg::ST_IDLE;
        end
      end
      mar_pkg::ST_MINIT: begin
        t_we = 1'b1;
        t_wa = j_q;
        t_wd = '0;
        ptop_d = 1'b0;
        i_d = '0;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          j_d = '0;
          state_d = mar_pkg::ST_MSTART;
        end
      end
      mar_pkg::ST_MSTART: begin
        abit_d = a_now;
        qbit_d = q_now;
        c_d = '0;
        state_d = mar_pkg::ST_MPASS;
      end
      mar_pkg::ST_MPASS: begin
        // P = (P + a*B + q*N) / 2, shifted down one digit behind the add
        alu_c.x = mem_t[j_q];
        alu_c.y = abit_q ? mem_b[b_idx] : '0;
        alu_c.z = qbit_q ? mem_n[j_q] : '0;
        c_d = alu_c.cout;
        prev_d = alu_c.sum;
        t_we = (j_q != '0);
        t_wa = j_q - 6'h01;
        t_wd = {alu_c.sum[0], prev_q[DW-1:1]};
        j_d = j_q + 6'h01;
        if (last_dig) begin
          j_d = j_q;
          state_d = mar_pkg::ST_MTOP;
        end
      end
      mar_pkg::ST_MTOP: begin
        t_we = 1'b1;
        t_wa = mod_size;
        t_wd = {ext[0], prev_q[DW-1:1]};
        ptop_d = ext[1];
        j_d = '0;
        bw_d = 1'b0;
        // top carry already folded into ptop; final subtract must not add it again
        c_d = '0;
        if (i_q == bits_last) begin
          state_d = mar_pkg::ST_MFINAL;
        end else begin
          i_d = i_q + 12'h001;
          state_d = mar_pkg::ST_MSTART;
        end
      end
      mar_pkg::ST_MFINAL: begin
        // A is only read; result lands over the B block
        alu_c.x = mem_t[j_q];
        alu_c.w = mem_n[j_q];
        b_we = 1'b1;
        b_wa = b_idx;
        b_wd = alu_c.diff;
        bw_d = alu_c.bout;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          j_d = '0;
          c_d = '0;
          if (ptop_q || !alu_c.bout) begin
            done_d = 1'b1;
            state_d = mar_pkg::ST_IDLE;
          end else begin
            state_d = mar_pkg::ST_COPY;
          end
        end
      end
      mar_pkg::ST_COPY: begin
        alu_c.x = mem_t[j_q];
        alu_c.cin = '0;
        b_we = 1'b1;
        b_wa = b_idx;
        b_wd = alu_c.sum;
        j_d = j_q + 6'h01;
        if (last_dig) begin
          done_d = 1'b1;
          state_d = mar_pkg::ST_IDLE;
        end
      end
      default: state_d = mar_pkg::ST_IDLE;
    endcase
    busy_d = (state_d != mar_pkg::ST_IDLE);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst) begin
      state_q <= mar_pkg::ST_CLEAR;
      j_q <= '0;
      i_q <= '0;
      c_q <= '0;
      bw_q <= 1'b0;
      ptop_q <= 1'b0;
      prev_q <= '0;
      abit_q <= 1'b0;
      qbit_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      j_q <= j_d;
      i_q <= i_d;
      c_q <= c_d;
      bw_q <= bw_d;
      ptop_q <= ptop_d;
      prev_q <= prev_d;
      abit_q <= abit_d;
      qbit_q <= qbit_d;
      done_q <= done_d;
      busy_q <= busy_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (a_we) begin
      mem_a[a_wa] <= a_wd;
    end
    if (b_we) begin
      mem_b[b_wa] <= b_wd;
    end
    if (n_we) begin
      mem_n[n_wa] <= n_wd;
    end
    if (t_we) begin
      mem_t[t_wa] <= t_wd;
    end
  end

  assign mem_rdata = rdata_q;
  assign busy = busy_q;
  assign done = done_q;
endmodule : mar_routines

`default_nettype wire

// ===== dv/mar_routines_props.sv
`timescale 1ns/10ps
`default_nettype none
module mar_routines_props (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // launch
  input wire logic start,
  input wire logic [11:0] entry_addr,
  input wire logic [5:0] mod_size,
  // memory port
  input wire logic mem_wr,
  input wire logic [1:0] mem_sel,
  input wire logic [5:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  // status
  input wire logic busy,
  input wire logic done
);
  logic rs;
  logic ok;
  logic [11:0] op_q, op_d;
  logic [15:0] n_q, n_d;
  int d;
  assign rs = rst | soft_rst;
  assign ok = entry_addr inside {12'h008, 12'h009, 12'h00B, 12'h00D};
  assign d = int'(mod_size) + 1;
  // routine in flight and its busy length
  always_comb begin
    op_d = (start && !busy && ok) ? entry_addr : op_q;
    n_d = busy ? n_q + 16'h1 : 16'h0;
    if (rs) begin
      op_d = 12'h00D;
      n_d = 16'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    op_q <= op_d;
    n_q <= n_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rs);
  property p_rst;
    disable iff (1'b0) rs |=> busy && !done && mem_rdata == 16'h0;
  endproperty
  property p_boot;
    $fell(rs) |-> ##63 !done ##1 done && !busy;
  endproperty
  property p_take;
    start && !busy && ok |=> busy && !done;
  endproperty
  property p_refuse;
    start && !busy && !ok |=> !busy && $stable(done);
  endproperty
  property p_hold;
    !busy && !start |=> $stable(done);
  endproperty
  property p_excl;
    done |-> !busy;
  endproperty
  property p_wr_rd;
    !busy && mem_wr ##1 !mem_wr && $stable(mem_sel) && $stable(mem_addr) |=> mem_rdata == $past(mem_wdata, 2);
  endproperty
  property p_clr_len;
    $fell(busy) && op_q == 12'h00D |-> n_q == 16'h40;
  endproperty
  property p_as_len;
    $fell(busy) && op_q inside {12'h008, 12'h009} |-> n_q == d || n_q == 2 * d;
  endproperty
  property p_mul_len;
    $fell(busy) && op_q == 12'h00B |-> n_q == 2 * d + 32 * d * (d + 2) || n_q == 3 * d + 32 * d * (d + 2);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_boot: assert property (p_boot) else $error("clear after reset mistimed");
  a_take: assert property (p_take) else $error("start not taken");
  a_refuse: assert property (p_refuse) else $error("bad entry taken");
  a_hold: assert property (p_hold) else $error("done moved while idle");
  a_excl: assert property (p_excl) else $error("done while busy");
  a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
  a_clr_len: assert property (p_clr_len) else $error("clear length wrong");
  a_as_len: assert property (p_as_len) else $error("add or sub length wrong");
  a_mul_len: assert property (p_mul_len) else $error("multiply length wrong");
  c_add: cover property ($fell(busy) && op_q == 12'h008);
  c_sub: cover property ($fell(busy) && op_q == 12'h009);
  c_mul: cover property ($fell(busy) && op_q == 12'h00B);
endmodule : mar_routines_props
bind mar_routines mar_routines_props i_mar_routines_props (
  .core_clk, .rst, .soft_rst, .start, .entry_addr, .mod_size, .mem_wr,
  .mem_sel, .mem_addr, .mem_wdata, .mem_rdata, .busy, .done
);
`default_nettype wire

// ===== dv/mar_host.sv
`timescale 1ns/10ps
`default_nettype none
module mar_host (
  // clock, status and read data
  input wire logic core_clk,
  input wire logic busy,
  input wire logic [15:0] mem_rdata,
  // launch
  output logic start,
  output logic [11:0] entry_addr,
  output logic [5:0] mod_size,
  output logic [1:0] a_sel,
  output logic [1:0] b_sel,
  // memory port
  output logic mem_wr,
  output logic [1:0] mem_sel,
  output logic [5:0] mem_addr,
  output logic [15:0] mem_wdata
);
  initial begin
    start = 1'b0;
    entry_addr = 12'h000;
    mod_size = 6'h04;
    a_sel = 2'h0;
    b_sel = 2'h0;
    mem_wr = 1'b0;
    mem_sel = 2'h0;
    mem_addr = 6'h00;
    mem_wdata = 16'h0000;
  end
  // five digits, least significant first
  task automatic put(input logic [1:0] s, input logic [5:0] b, input logic [79:0] v);
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      mem_wr = 1'b1;
      mem_sel = s;
      mem_addr = b + 6'(i);
      mem_wdata = v[16*i+:16];
    end
    @(negedge core_clk);
    mem_wr = 1'b0;
    mem_wdata = ~mem_wdata;
  endtask : put
  task automatic get(input logic [1:0] s, input logic [5:0] b, output logic [79:0] v);
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      mem_sel = s;
      mem_addr = b + 6'(i);
      @(negedge core_clk);
      v[16*i+:16] = mem_rdata;
    end
  endtask : get
  task automatic run(input logic [11:0] e, input logic [1:0] as, input logic [1:0] bs);
    int n;
    @(negedge core_clk);
    a_sel = as;
    b_sel = bs;
    entry_addr = e;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : run
endmodule : mar_host
`default_nettype wire

// ===== dv/test_modular_arith_routines.sv
`timescale 1ns/10ps
`default_nettype none
module test_modular_arith_routines;
  typedef struct {
    logic [11:0] e;
    logic [1:0] as;
    logic [1:0] bs;
    logic [79:0] a;
    logic [79:0] b;
    logic [79:0] x;
  } mar_row_s;
  localparam logic [79:0] NM = 80'h8000_0000_0000_0000_0005;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic start, mem_wr, busy, done;
  logic [11:0] entry_addr;
  logic [5:0] mod_size, mem_addr;
  logic [1:0] a_sel, b_sel, mem_sel;
  logic [15:0] mem_wdata, mem_rdata;
  logic [79:0] v;
  logic [81:0] m;
  int miscompares = 0;
  int comparisons = 0;
  mar_row_s rows [6] = '{
    '{12'h008, 2'h0, 2'h0, 80'h1_0000_FFFF, 80'h1, 80'h1_0001_0000},
    '{12'h008, 2'h0, 2'h0, NM - 80'h1, 80'h2, 80'h1},
    '{12'h008, 2'h1, 2'h2, 80'h7FFF_FFFF_FFFF_FFFF_FFFF, 80'h7FFF_FFFF_FFFF_FFFF_FFFF, 80'h7FFF_FFFF_FFFF_FFFF_FFF9},
    '{12'h009, 2'h0, 2'h0, 80'h1, 80'h2, NM - 80'h1},
    '{12'h009, 2'h2, 2'h1, 80'h1234, 80'h1234, 80'h0},
    '{12'h009, 2'h0, 2'h3, 80'h1_0000_0000, 80'h1, 80'hFFFF_FFFF}
  };
  always #4 core_clk = ~core_clk;
  mar_routines i_mar_routines (
    .core_clk, .rst, .soft_rst, .start, .entry_addr, .mod_size, .a_sel, .b_sel,
    .mem_wr, .mem_sel, .mem_addr, .mem_wdata, .mem_rdata, .busy, .done
  );
  mar_host i_mar_host (
    .core_clk, .busy, .mem_rdata, .start, .entry_addr, .mod_size, .a_sel, .b_sel,
    .mem_wr, .mem_sel, .mem_addr, .mem_wdata
  );
  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    for (int k = 0; k < 100 && busy !== 1'b0; k++) @(negedge core_clk);
    chk("boot status", 80'h1, {busy, done});
    i_mar_host.get(2'h2, 6'h3B, v);
    chk("boot memory", 80'h0, v);
    $display("boot done");
    i_mar_host.put(2'h2, 6'h00, NM);
    foreach (rows[i]) begin
      i_mar_host.put(2'h0, {rows[i].as, 4'h0}, rows[i].a);
      i_mar_host.put(2'h1, {rows[i].bs, 4'h0}, rows[i].b);
      i_mar_host.run(rows[i].e, rows[i].as, rows[i].bs);
      i_mar_host.get(2'h1, {rows[i].bs, 4'h0}, v);
      chk("result", rows[i].x, v);
      chk("status", 80'h1, {busy, done});
      $display("row %0d done", i);
    end
    i_mar_host.put(2'h0, 6'h00, 80'h3);
    i_mar_host.put(2'h1, 6'h00, 80'h5);
    i_mar_host.run(12'h00B, 2'h0, 2'h0);
    m = 82'hF;
    for (int k = 0; k < 160; k++) m = (m + (m[0] ? {2'h0, NM} : 82'h0)) >> 1;
    i_mar_host.get(2'h1, 6'h00, v);
    chk("product", m[79:0], v);
    i_mar_host.get(2'h0, 6'h00, v);
    chk("a kept", 80'h3, v);
    i_mar_host.run(12'h00A, 2'h0, 2'h0);
    chk("bad entry", 80'h1, {busy, done});
    $display("multiply and refusal done");
    i_mar_host.put(2'h3, 6'h10, 80'hFFFF_FFFF_FFFF_FFFF_FFFF);
    i_mar_host.run(12'h00D, 2'h0, 2'h0);
    i_mar_host.get(2'h3, 6'h10, v);
    chk("scratch cleared", 80'h0, v);
    i_mar_host.get(2'h2, 6'h00, v);
    chk("modulus cleared", 80'h0, v);
    i_mar_host.put(2'h1, 6'h00, 80'h5);
    fork
      i_mar_host.run(12'h00B, 2'h0, 2'h0);
      begin
        repeat (100) @(negedge core_clk);
        soft_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        soft_rst = 1'b0;
      end
    join
    chk("soft reset status", 80'h1, {busy, done});
    i_mar_host.get(2'h1, 6'h00, v);
    chk("soft reset clear", 80'h0, v);
    $display("clear and soft reset done");
    close_out;
  end
endmodule : test_modular_arith_routines
`default_nettype wire
